// >>> hdl/crsc_top.sv
/*
 * Clock, reset and standby control: ratio selection, stop wake-up wait,
 * reset stretching and cause, halt and stop entry and exit.
 * Assumes wake requests already qualified by the interrupt controller.
 */
// The placing of the registers and the Wishbone slave port were left to the implementer.
// Behaviour
// - ratio register resets to zero; unused bits of all registers read zero
// - loop on: ratio 00 half, 01 equal, 10/11 double base clock
// - loop off: ratio 00 /8, 01 /4, 10 /2, 11 undivided
// - wait code 00 32768, 01 16384, 10 1024, 11 one clock
// - clocks held off until wait elapses, then delivered
// - reset cause bit 0: pin reset clears, watchdog sets
// - pin reset holds internal reset for low time plus nine clocks
// - pin reset clears standby and reset cause
// - watchdog asserts internal reset nine clocks, this block kept
// - watchdog reset keeps ratio and wait select
// - watchdog reset clears standby, sets reset cause
// - stop disables crystal oscillator when it is the source
// - halt bit stops processor clock, peripherals run
// - halt ends on fast request, leveled request or any reset
// - low-level request ends standby without reaching processor
// - stop bit shuts processor, oscillator, loop, peripherals
// - stop ends on fast, external, suspend request or pin reset
// - interrupt wake from stop runs wait; pin reset skips it
// - in stop, oscillator, loop and usb run if usb keeps them
// - standby and ratio writes need the unlock key just before
// - standby holds stop bit 1, halt bit 0, cleared on wake
// - standby writes ignored while a wake request is pending
`timescale 1ns/100ps
module crsc_top (
    // clock and pin reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic RESET_PIN_N,
    input wire logic LOOP_ENABLE_PIN,
    // watchdog
    input wire logic WATCHDOG_OVERFLOW,
    // wake sources, same clock domain
    input wire logic FAST_REQUEST,
    input wire logic FAST_REQUEST_MASK,
    input wire logic LEVELED_REQUEST,
    input wire logic EXTERNAL_LEVELED_REQUEST,
    input wire logic SUSPEND_LEVELED_REQUEST,
    input wire logic USB_KEEPS_OSC,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // clock and reset outputs
    output logic INTERNAL_RESET,
    output logic CPU_CLOCK_TICK,
    output logic PERIPH_CLOCK_TICK,
    output logic [1:0] LOOP_MULTIPLY,
    output logic OSC_ENABLE,
    output logic LOOP_POWER,
    output logic [1:0] STANDBY_STATE
);
    import crsc_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_pin_sync;
    logic [1:0] loop_sync;

    always_ff @(posedge CLK) begin
        if (RST) begin
            // pin idles high; a zero here would fake a pin reset after RST
            rst_pin_sync <= 2'h3;
            loop_sync <= 2'h0;
        end else begin
            rst_pin_sync <= {rst_pin_sync[0], RESET_PIN_N};
            loop_sync <= {loop_sync[0], LOOP_ENABLE_PIN};
        end
    end

    logic pin_low;
    logic loop_on;
    assign pin_low = !rst_pin_sync[1];
    assign loop_on = loop_sync[1];

    // ------------------------------------------------------------------
    // reset stretching
    // ------------------------------------------------------------------
    logic [3:0] stretch;
    logic wd_pulse;
    logic wd_prev;

    always_ff @(posedge CLK) begin
        if (RST) begin
            wd_prev <= 1'b0;
        end else begin
            wd_prev <= WATCHDOG_OVERFLOW;
        end
    end
    assign wd_pulse = WATCHDOG_OVERFLOW && !wd_prev;

    always_ff @(posedge CLK) begin
        if (RST) begin
            stretch <= CRSC_STRETCH;
        end else if (pin_low) begin
            stretch <= CRSC_STRETCH;
        end else if (wd_pulse) begin
            // the pulse cycle itself is the first of the nine
            stretch <= CRSC_STRETCH - 4'h1;
        end else if (stretch != 4'h0) begin
            stretch <= stretch - 4'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            INTERNAL_RESET <= 1'b1;
        end else begin
            INTERNAL_RESET <= pin_low || wd_pulse || (stretch != 4'h0);
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] ratio_field;
    logic [1:0] wait_count_field;
    logic watchdog_cause_flag;
    logic unlock_standby;
    logic unlock_ratio;
    logic bus_req;
    logic wr_en;
    logic full_word;
    logic pending;
    crsc_mode_t mode;
    crsc_mode_t next_mode;

    assign bus_req = CYC_I && STB_I && !ACK_O;
    assign wr_en = bus_req && WE_I;
    assign full_word = SEL_I == 4'hF;
    assign pending = (FAST_REQUEST && !FAST_REQUEST_MASK) || LEVELED_REQUEST;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= bus_req;
        end
    end

    // key must be the immediately preceding write to the same register
    always_ff @(posedge CLK) begin
        if (RST || pin_low) begin
            unlock_standby <= 1'b0;
            unlock_ratio <= 1'b0;
        end else if (wr_en) begin
            unlock_standby <= (ADR_I == CRSC_OFS_STANDBY) && full_word &&
                !unlock_standby && (DAT_I == CRSC_UNLOCK_KEY);
            unlock_ratio <= (ADR_I == CRSC_OFS_RATIO) && full_word &&
                !unlock_ratio && (DAT_I == CRSC_UNLOCK_KEY);
        end
    end

    // ratio and wait survive a watchdog reset: only RST and the pin clear
    always_ff @(posedge CLK) begin
        if (RST || pin_low) begin
            ratio_field <= CRSC_FIELD_RESET;
        end else if (wr_en && ADR_I == CRSC_OFS_RATIO && unlock_ratio &&
                     SEL_I[0]) begin
            ratio_field <= DAT_I[1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || pin_low) begin
            wait_count_field <= CRSC_FIELD_RESET;
        end else if (wr_en && ADR_I == CRSC_OFS_WAIT && SEL_I[0]) begin
            wait_count_field <= DAT_I[1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || pin_low) begin
            watchdog_cause_flag <= 1'b0;
        end else if (wd_pulse) begin
            watchdog_cause_flag <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            DAT_O <= CRSC_ZERO;
        end else if (bus_req && !WE_I) begin
            if (ADR_I == CRSC_OFS_RATIO) begin
                DAT_O <= {CRSC_ZERO[31:2], ratio_field};
            end else if (ADR_I == CRSC_OFS_WAIT) begin
                DAT_O <= {CRSC_ZERO[31:2], wait_count_field};
            end else if (ADR_I == CRSC_OFS_CAUSE) begin
                DAT_O <= {CRSC_ZERO[31:1], watchdog_cause_flag};
            end else begin
                DAT_O <= CRSC_ZERO;
            end
        end else begin
            DAT_O <= CRSC_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // standby state machine
    // ------------------------------------------------------------------
    logic [15:0] wait_cnt;
    logic [15:0] wait_load;
    logic standby_write;
    logic stop_wake;

    assign standby_write = wr_en && ADR_I == CRSC_OFS_STANDBY &&
        unlock_standby && SEL_I[0] && !pending;
    assign stop_wake = (FAST_REQUEST && !FAST_REQUEST_MASK) ||
        EXTERNAL_LEVELED_REQUEST || SUSPEND_LEVELED_REQUEST;

    always_comb begin
        case (wait_count_field)
            2'b00: wait_load = CRSC_WAIT_00;
            2'b01: wait_load = CRSC_WAIT_01;
            2'b10: wait_load = CRSC_WAIT_10;
            default: wait_load = CRSC_WAIT_11;
        endcase
    end

    always_comb begin
        next_mode = mode;
        case (mode)
            CRSC_RUN: begin
                if (standby_write && DAT_I[CRSC_STOP_BIT]) begin
                    next_mode = CRSC_STOP;
                end else if (standby_write && DAT_I[CRSC_HALT_BIT]) begin
                    next_mode = CRSC_HALT;
                end
            end
            CRSC_HALT: begin
                // level-only requests still wake, forwarding is elsewhere
                if (pending) begin
                    next_mode = CRSC_RUN;
                end
            end
            CRSC_STOP: begin
                if (stop_wake) begin
                    next_mode = CRSC_WAKE;
                end
            end
            CRSC_WAKE: begin
                if (wait_cnt == 16'h0000) begin
                    next_mode = CRSC_RUN;
                end
            end
            default: next_mode = CRSC_RUN;
        endcase
        // resets must reach the registered standby and power outputs too
        if (pin_low || wd_pulse) begin
            next_mode = CRSC_RUN;
        end
    end

    // any reset clears standby; pin reset needs no settling wait
    always_ff @(posedge CLK) begin
        if (RST || pin_low || wd_pulse) begin
            mode <= CRSC_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_cnt <= CRSC_WAIT_11;
        end else if (mode == CRSC_STOP) begin
            wait_cnt <= wait_load;
        end else if (mode == CRSC_WAKE && wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            STANDBY_STATE <= 2'h0;
            OSC_ENABLE <= 1'b1;
            LOOP_POWER <= 1'b1;
        end else begin
            STANDBY_STATE <= {next_mode == CRSC_STOP,
                              next_mode == CRSC_HALT};
            OSC_ENABLE <= next_mode != CRSC_STOP ||
                USB_KEEPS_OSC;
            LOOP_POWER <= (next_mode != CRSC_STOP || USB_KEEPS_OSC) &&
                loop_on;
        end
    end

    // ------------------------------------------------------------------
    // clock ratio
    // ------------------------------------------------------------------
    logic [2:0] div_mask;
    logic periph_run;
    logic periph_tick;

    always_ff @(posedge CLK) begin
        if (RST) begin
            LOOP_MULTIPLY <= CRSC_CK_HALF;
            div_mask <= CRSC_DIV_EIGHT;
        end else if (loop_on) begin
            div_mask <= CRSC_DIV_ONE;
            if (ratio_field == 2'b00) begin
                LOOP_MULTIPLY <= CRSC_CK_HALF;
            end else if (ratio_field == 2'b01) begin
                LOOP_MULTIPLY <= CRSC_CK_FULL;
            end else begin
                LOOP_MULTIPLY <= CRSC_CK_DOUBLE;
            end
        end else begin
            LOOP_MULTIPLY <= CRSC_CK_FULL;
            if (ratio_field == 2'b00) begin
                div_mask <= CRSC_DIV_EIGHT;
            end else if (ratio_field == 2'b01) begin
                div_mask <= CRSC_DIV_FOUR;
            end else if (ratio_field == 2'b10) begin
                div_mask <= CRSC_DIV_TWO;
            end else begin
                div_mask <= CRSC_DIV_ONE;
            end
        end
    end

    assign periph_run = mode == CRSC_RUN || mode == CRSC_HALT;

    crsc_clock_gate u_gate (
        .clk(CLK),
        .rst(RST),
        .run(periph_run),
        .div_mask(div_mask),
        .tick(periph_tick)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            PERIPH_CLOCK_TICK <= 1'b0;
            CPU_CLOCK_TICK <= 1'b0;
        end else begin
            PERIPH_CLOCK_TICK <= periph_tick;
            CPU_CLOCK_TICK <= periph_tick && mode == CRSC_RUN;
        end
    end
endmodule : crsc_top

// >>> hdl/crsc_pkg.sv
/*
 * Constants for the clock, reset and standby control block: register
 * offsets, field layouts, reset values, unlock key, wait counts.
 * Assumes a 32-bit classic Wishbone bus with word-aligned registers.
 */
package crsc_pkg;
    // -------------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [3:0] CRSC_OFS_STANDBY = 4'h0;
    localparam logic [3:0] CRSC_OFS_RATIO = 4'h4;
    localparam logic [3:0] CRSC_OFS_WAIT = 4'h8;
    localparam logic [3:0] CRSC_OFS_CAUSE = 4'hC;
    localparam logic [31:0] CRSC_UNLOCK_KEY = 32'h0000_003C;
    localparam logic [31:0] CRSC_ZERO = 32'h0000_0000;
    localparam logic [1:0] CRSC_FIELD_RESET = 2'h0;
    localparam int CRSC_HALT_BIT = 0;
    localparam int CRSC_STOP_BIT = 1;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam logic [3:0] CRSC_STRETCH = 4'h9;
    localparam logic [15:0] CRSC_WAIT_00 = 16'h7FFF;
    localparam logic [15:0] CRSC_WAIT_01 = 16'h3FFF;
    localparam logic [15:0] CRSC_WAIT_10 = 16'h03FF;
    localparam logic [15:0] CRSC_WAIT_11 = 16'h0000;
    localparam logic [2:0] CRSC_DIV_ONE = 3'h0;
    localparam logic [2:0] CRSC_DIV_TWO = 3'h1;
    localparam logic [2:0] CRSC_DIV_FOUR = 3'h3;
    localparam logic [2:0] CRSC_DIV_EIGHT = 3'h7;

    typedef enum logic [1:0] {
        CRSC_RUN = 2'b00,
        CRSC_HALT = 2'b01,
        CRSC_STOP = 2'b10,
        CRSC_WAKE = 2'b11
    } crsc_mode_t;

    typedef enum logic [1:0] {
        CRSC_CK_HALF = 2'b00,
        CRSC_CK_FULL = 2'b01,
        CRSC_CK_DOUBLE = 2'b10
    } crsc_ck_t;
endpackage : crsc_pkg

// >>> hdl/crsc_clock_gate.sv
/*
 * Clock enable generator: turns the ratio selection into a glitch-free
 * enable pulse train for the processor and peripherals.
 * Assumes a free-running base clock; the enable is registered.
 */
`timescale 1ns/100ps
module crsc_clock_gate (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [2:0] div_mask,
    // result
    output logic tick
);
    import crsc_pkg::*;

    logic [2:0] phase;

    // ratio change applies to the count in progress; phase restarts from zero at a tick or while run is low, so no runt periods
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            phase <= CRSC_DIV_ONE;
        end else if ((phase & div_mask) == div_mask) begin
            phase <= CRSC_DIV_ONE;
        end else begin
            phase <= phase + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= run && ((phase & div_mask) == div_mask);
        end
    end
endmodule : crsc_clock_gate

// >>> bench/crsc_top_sva.sv
/*
 * Checker for the clock, reset and standby control block.
 * Sees only the top ports; bound into every crsc_top instance.
 */
`timescale 1ns/100ps
module crsc_top_sva (
    // clock and resets
    input wire logic CLK,
    input wire logic RST,
    input wire logic RESET_PIN_N,
    input wire logic WATCHDOG_OVERFLOW,
    // wake sources
    input wire logic FAST_REQUEST,
    input wire logic FAST_REQUEST_MASK,
    input wire logic LEVELED_REQUEST,
    input wire logic EXTERNAL_LEVELED_REQUEST,
    input wire logic SUSPEND_LEVELED_REQUEST,
    input wire logic USB_KEEPS_OSC,
    // bus
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    // outputs
    input wire logic INTERNAL_RESET,
    input wire logic CPU_CLOCK_TICK,
    input wire logic PERIPH_CLOCK_TICK,
    input wire logic OSC_ENABLE,
    input wire logic LOOP_POWER,
    input wire logic [1:0] STANDBY_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_ACK_PULSE: assert property (
        CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
        else $error("ack not a one cycle pulse");
    AST_RSVD_ZERO: assert property (ACK_O |-> DAT_O[31:2] == 30'h0)
        else $error("unused read bits not zero");
    AST_PIN_STRETCH: assert property (
        $rose(RESET_PIN_N) |=> INTERNAL_RESET [*8])
        else $error("pin reset stretch too short");
    AST_WDOG_STRETCH: assert property (
        $rose(WATCHDOG_OVERFLOW) |-> ##[1:2] INTERNAL_RESET [*8])
        else $error("watchdog reset too short");
    AST_HALT_CPU: assert property (
        STANDBY_STATE == 2'b01 && $past(STANDBY_STATE, 2) == 2'b01
        |-> !CPU_CLOCK_TICK)
        else $error("processor clock runs in halt");
    AST_STOP_OFF: assert property (
        STANDBY_STATE[1] && $past(STANDBY_STATE[1], 2)
        |-> !CPU_CLOCK_TICK && !PERIPH_CLOCK_TICK)
        else $error("clocks run in stop");
    AST_STOP_OSC: assert property (
        STANDBY_STATE[1] && $past(STANDBY_STATE[1], 2) && !USB_KEEPS_OSC
        && $stable(USB_KEEPS_OSC) |-> !OSC_ENABLE && !LOOP_POWER)
        else $error("oscillator kept in stop");
    AST_USB_KEEP: assert property (
        STANDBY_STATE[1] && $past(STANDBY_STATE[1], 2) && USB_KEEPS_OSC
        && $stable(USB_KEEPS_OSC) |-> OSC_ENABLE && LOOP_POWER)
        else $error("oscillator off while usb keeps it");
    AST_HALT_WAKE: assert property (
        STANDBY_STATE == 2'b01 && (LEVELED_REQUEST
        || FAST_REQUEST && !FAST_REQUEST_MASK) |-> ##[1:3] STANDBY_STATE == 0)
        else $error("halt not left on request");
    AST_STOP_WAKE: assert property (
        STANDBY_STATE[1] && (EXTERNAL_LEVELED_REQUEST
        || SUSPEND_LEVELED_REQUEST || FAST_REQUEST && !FAST_REQUEST_MASK)
        |-> ##[1:3] !STANDBY_STATE[1])
        else $error("stop not left on request");
    AST_BUSY_IGNORE: assert property (
        STANDBY_STATE == 2'b00 && LEVELED_REQUEST |=> STANDBY_STATE == 2'b00)
        else $error("standby entered with request pending");
endmodule : crsc_top_sva

bind crsc_top crsc_top_sva i_sva (.CLK(CLK), .RST(RST),
    .RESET_PIN_N(RESET_PIN_N), .WATCHDOG_OVERFLOW(WATCHDOG_OVERFLOW),
    .FAST_REQUEST(FAST_REQUEST), .FAST_REQUEST_MASK(FAST_REQUEST_MASK),
    .LEVELED_REQUEST(LEVELED_REQUEST),
    .EXTERNAL_LEVELED_REQUEST(EXTERNAL_LEVELED_REQUEST),
    .SUSPEND_LEVELED_REQUEST(SUSPEND_LEVELED_REQUEST),
    .USB_KEEPS_OSC(USB_KEEPS_OSC), .CYC_I(CYC_I), .STB_I(STB_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .INTERNAL_RESET(INTERNAL_RESET),
    .CPU_CLOCK_TICK(CPU_CLOCK_TICK), .PERIPH_CLOCK_TICK(PERIPH_CLOCK_TICK),
    .OSC_ENABLE(OSC_ENABLE), .LOOP_POWER(LOOP_POWER),
    .STANDBY_STATE(STANDBY_STATE));

// >>> bench/crsc_partner.sv
/*
 * Far-side model: reset pin, watchdog source, interrupt controller.
 * Assumes the bench calls its tasks; all outputs move after CLK edges.
 */
`timescale 1ns/100ps
module crsc_partner (
    // clock and standby view
    input wire logic clk,
    input wire logic [1:0] standby_state,
    // sources: req = {suspend, external, leveled, fast}
    output logic reset_pin_n,
    output logic watchdog_overflow,
    output logic [3:0] req
);
    initial begin
        reset_pin_n = 1'b1;
        watchdog_overflow = 1'b0;
        req = 4'h0;
    end
    // a request stays pending until standby is left, then some more
    task automatic wake(input int i, input int hold);
        int n;
        n = 0;
        @(posedge clk);
        req[i] <= 1'b1;
        while (standby_state !== 2'b00 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        repeat (hold) @(posedge clk);
        req[i] <= 1'b0;
    endtask : wake
    task automatic pin_reset(input int len);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (len) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask : pin_reset
    task automatic wdog();
        @(posedge clk);
        watchdog_overflow <= 1'b1;
        @(posedge clk);
        watchdog_overflow <= 1'b0;
    endtask : wdog
endmodule : crsc_partner

// >>> bench/clock_reset_standby_control_test.sv
/*
 * Self-checking bench for the clock, reset and standby control block.
 * Assumes crsc_partner for reset and wake sources, checker bound in.
 */
`timescale 1ns/100ps
module clock_reset_standby_control_test;
    import crsc_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end end
    logic clk = 1'b0, rst = 1'b1, loop_pin = 1'b1, usb = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fmask = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    wire logic [31:0] dat_o;
    wire logic ack, irst, cpu_t, per_t, osc, lpow, rpin, wdog;
    wire logic [1:0] lmul, sby;
    wire logic [3:0] req;
    int n_mismatch = 0, num_checks = 0;
    always #20 clk = ~clk;
    crsc_top i_dut (.CLK(clk), .RST(rst), .RESET_PIN_N(rpin),
        .LOOP_ENABLE_PIN(loop_pin), .WATCHDOG_OVERFLOW(wdog),
        .FAST_REQUEST(req[0]), .FAST_REQUEST_MASK(fmask),
        .LEVELED_REQUEST(req[1]), .EXTERNAL_LEVELED_REQUEST(req[2]),
        .SUSPEND_LEVELED_REQUEST(req[3]), .USB_KEEPS_OSC(usb),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
        .INTERNAL_RESET(irst), .CPU_CLOCK_TICK(cpu_t),
        .PERIPH_CLOCK_TICK(per_t), .LOOP_MULTIPLY(lmul),
        .OSC_ENABLE(osc), .LOOP_POWER(lpow), .STANDBY_STATE(sby));
    crsc_partner i_far (.clk(clk), .standby_state(sby),
        .reset_pin_n(rpin), .watchdog_overflow(wdog), .req(req));
    // --------------------------------
    // bus and measuring helpers
    // --------------------------------
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask : rd
    task automatic kw(input logic [3:0] a, input logic [31:0] d);
        wr(a, CRSC_UNLOCK_KEY);
        wr(a, d);
    endtask : kw
    task automatic ticks(input int len, output int c, output int u);
        c = 0;
        u = 0;
        repeat (len) begin
            @(posedge clk);
            c += per_t;
            u += cpu_t;
        end
    endtask : ticks
    task automatic hi_len(output int m);
        int n;
        n = 0;
        m = 0;
        while (irst !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        while (irst === 1'b1 && m < 200) begin
            @(posedge clk);
            m++;
        end
    endtask : hi_len
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs();
        rd(CRSC_OFS_RATIO, 32'h0000_0000);
        rd(CRSC_OFS_WAIT, 32'h0000_0000);
        rd(CRSC_OFS_STANDBY, 32'h0000_0000);
        rd(4'h2, 32'h0000_0000);
        // a write elsewhere between key and value cancels the key
        wr(CRSC_OFS_RATIO, CRSC_UNLOCK_KEY);
        wr(CRSC_OFS_WAIT, 32'h0000_0002);
        wr(CRSC_OFS_RATIO, 32'h0000_0003);
        rd(CRSC_OFS_RATIO, 32'h0000_0000);
        rd(CRSC_OFS_WAIT, 32'h0000_0002);
    endtask : t_regs
    task automatic t_ratio();
        int c, u;
        logic [1:0] m;
        for (int l = 0; l < 2; l++) begin
            for (int r = 0; r < 4; r++) begin
                @(posedge clk);
                loop_pin <= l[0];
                kw(CRSC_OFS_RATIO, 32'(r));
                rd(CRSC_OFS_RATIO, 32'(r));
                repeat (16) @(posedge clk);
                ticks(64, c, u);
                m = (l == 0) ? 2'h1 : (r < 2) ? 2'(r) : 2'h2;
                `CHK(lmul, m)
                `CHK(c, (l == 1) ? 64 : 64 >> (3 - r))
                `CHK(u, c)
            end
        end
    endtask : t_ratio
    task automatic t_stop();
        int n;
        int cnt[4] = '{32768, 16384, 1024, 1};
        int src[4] = '{0, 2, 3, 2};
        for (int w = 0; w < 4; w++) begin
            wr(CRSC_OFS_WAIT, 32'(w));
            @(posedge clk);
            usb <= (w == 1);
            loop_pin <= (w != 3);
            kw(CRSC_OFS_STANDBY, 32'h0000_0002);
            repeat (3) @(posedge clk);
            `CHK(sby, 2'h2)
            `CHK(osc, w == 1)
            `CHK(lpow, w == 1)
            `CHK(per_t, 1'b0)
            fork
                i_far.wake(src[w], 3);
                begin
                    n = 0;
                    @(posedge clk);
                    while (per_t !== 1'b1 && n < 40000) begin
                        @(posedge clk);
                        n++;
                    end
                end
            join
            `CHK(n>=cnt[w] && n<=cnt[w]+8, 1'b1)
            `CHK(sby, 2'h0)
        end
    endtask : t_stop
    task automatic t_halt();
        int c, u;
        kw(CRSC_OFS_STANDBY, 32'h0000_0001);
        repeat (3) @(posedge clk);
        `CHK(sby, 2'h1)
        ticks(16, c, u);
        `CHK(u, 0)
        `CHK(c, 16)
        i_far.wake(1, 3);
        `CHK(sby, 2'h0)
        fork
            i_far.wake(1, 30);
            begin
                kw(CRSC_OFS_STANDBY, 32'h0000_0001);
                `CHK(sby, 2'h0)
            end
        join
        // a masked fast request neither blocks halt entry nor wakes
        @(posedge clk);
        fmask <= 1'b1;
        fork
            i_far.wake(0, 40);
            begin
                kw(CRSC_OFS_STANDBY, 32'h0000_0001);
                `CHK(sby, 2'h1)
                repeat (8) @(posedge clk);
                `CHK(sby, 2'h1)
                fmask <= 1'b0;
                repeat (3) @(posedge clk);
                `CHK(sby, 2'h0)
            end
        join
    endtask : t_halt
    task automatic t_resets();
        int m, c, u;
        kw(CRSC_OFS_RATIO, 32'h0000_0002);
        wr(CRSC_OFS_WAIT, 32'h0000_0001);
        kw(CRSC_OFS_STANDBY, 32'h0000_0001);
        i_far.wdog();
        hi_len(m);
        `CHK(m >= 9 && m <= 11, 1'b1)
        `CHK(sby, 2'h0)
        rd(CRSC_OFS_CAUSE, 32'h0000_0001);
        rd(CRSC_OFS_RATIO, 32'h0000_0002);
        rd(CRSC_OFS_WAIT, 32'h0000_0001);
        kw(CRSC_OFS_STANDBY, 32'h0000_0002);
        fork
            i_far.pin_reset(20);
            hi_len(m);
        join
        `CHK(m >= 28 && m <= 33, 1'b1)
        `CHK(sby, 2'h0)
        ticks(16, c, u);
        `CHK(c > 0, 1'b1)
        rd(CRSC_OFS_CAUSE, 32'h0000_0000);
    endtask : t_resets
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ratio();
        t_stop();
        t_halt();
        t_resets();
        close_out();
    end
    // the stop waits dominate: about 51000 cycles in all
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule : clock_reset_standby_control_test
